// ===== hw/cmdsync_regs.svh
`ifndef CMDSYNC_REGS_SVH
`define CMDSYNC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CS_OFF_CMD   8'h00
`define CS_OFF_ESR   8'h04
`define CS_OFF_ESE   8'h08
`define CS_OFF_SRE   8'h0c
`define CS_OFF_STB   8'h10
`define CS_OFF_OUTQ  8'h14
`define CS_OFF_STAT  8'h18
`define CS_OFF_ISTAT 8'h1c
`define CS_OFF_IMASK 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CS_ESR_OPC   0
`define CS_ESR_REF   2
`define CS_ESR_CME   5
`define CS_STB_MAV   4
`define CS_STB_ESB   5
`define CS_STB_MSS   6
`define CS_INT_OPC   0
`define CS_INT_REPLY 1
`define CS_INT_REF   2
`define CS_INT_SRQ   3

// ----------------------------------------
// Command codes, reply and reset values
// ----------------------------------------
`define CS_CMD_OPC   4'h1
`define CS_CMD_OPCQ  4'h2
`define CS_CMD_WAI   4'h3
`define CS_CMD_RST   4'h4
`define CS_CMD_CLS   4'h5
`define CS_CMD_OVL   4'h6
`define CS_REPLY_ONE 8'h01
`define CS_RST_8     8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define CS_CLK_NS    10
`define CS_RST_NS    1000
`define CS_RST_CYC   (`CS_RST_NS / `CS_CLK_NS)

`endif

// ===== hw/cmdsync_pkg.sv
package cmdsync_pkg;
  typedef enum logic [1:0] {
    CS_IDLE,
    CS_WAI,
    CS_OPCQ
  } cs_state_e;
  typedef logic [7:0] cs_byte_t;
endpackage

// ===== hw/cmdsync_oq_if.sv
`timescale 1ns/1ps
interface cmdsync_oq_if;
  logic                 push;
  cmdsync_pkg::cs_byte_t wdata;
  logic                 full;
  logic                 pop;
  cmdsync_pkg::cs_byte_t rdata;
  logic                 empty;
  modport queue (input push, input wdata, input pop, output full, output rdata, output empty);
  modport user  (output push, output wdata, output pop, input full, input rdata, input empty);
endinterface

// ===== hw/cmdsync_outq.sv
`timescale 1ns/1ps
module cmdsync_outq #(
  parameter int DEPTH = 4
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  cmdsync_oq_if.queue q
);
  import cmdsync_pkg::*;
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("cmdsync_outq: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  cs_byte_t       mem [DEPTH];
  logic [AW-1:0]  wr_ptr_reg;
  logic [AW-1:0]  rd_ptr_reg;
  logic [AW:0]    cnt_reg;
  cs_byte_t       rdata_reg;
  logic           head_reg;
  logic           do_push;
  logic           do_pop;

  assign do_push = q.push && (cnt_reg != (AW+1)'(DEPTH));
  assign do_pop  = q.pop && head_reg;
  assign q.full  = (cnt_reg == (AW+1)'(DEPTH));
  assign q.rdata = rdata_reg;
  assign q.empty = ~head_reg;

  always_ff @(posedge i_clk) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= q.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (do_push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (do_pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // Registered head word and its valid flag
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= '0;
      head_reg  <= 1'b0;
    end else begin
      rdata_reg <= mem[rd_ptr_reg];
      head_reg  <= (cnt_reg != '0) && !do_pop;
    end
  end
endmodule

// ===== hw/cmdsync.sv
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "cmdsync_regs.svh"

// Summary of operation
// - *OPC sets ESR bit 0 only after all earlier commands finish.
// - *OPC? blocks commands until nothing pends, then queues reply 1.
// - *WAI blocks later commands until all earlier ones complete.
// - ESE bit 0 enables the operation-complete event into ESB.
// - SRE bit 5 lets a set ESB raise a service request.
// - SRE bit 4 lets message-available raise a service request.
// - Repeated *OPC then ESR read returns LSB 1 once done.
// - Setting commands in one line may run out of order.
// - *RST is overlapped; a later *OPC waits for reset to finish.
// - *CLS drops a pending *OPC; it is refused unless the state is idle.
// - Status reads are answered even while a blocking wait runs.
// - *CLS clears ESR, ISTAT and the service request; the output queue and pending count are kept.
// - Blocking operations refuse other commands; *OPC? then queues 1.
// - State and errors are recorded in readable status registers.
// - Status byte bit rising while enabled raises a service request.
// - Reading an event register returns and clears it.
module cmdsync #(
  parameter int RST_CYCLES = `CS_RST_CYC,
  parameter int PEND_W     = 4,
  parameter int OQ_DEPTH   = 4
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  i_op_done,
  output logic                       o_op_start,
  output logic                       o_rst_active,
  output logic                       o_srq,
  output logic                       o_irq,
  output cmdsync_pkg::cs_state_e     o_state
);
  import cmdsync_pkg::*;

  generate
    if (RST_CYCLES < 8 || PEND_W < 1) begin : g_chk
      $error("cmdsync: RST_CYCLES must be at least 8 and PEND_W at least 1");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cmdsync_oq_if oq ();

  cs_state_e          state_reg;
  cs_byte_t           esr_reg;
  cs_byte_t           ese_reg;
  cs_byte_t           sre_reg;
  cs_byte_t           istat_reg;
  cs_byte_t           imask_reg;
  logic               opc_pend_reg;
  logic [PEND_W-1:0]  pend_cnt_reg;
  logic [31:0]        rst_cnt_reg;
  logic               done_s1_reg;
  logic               done_s2_reg;
  logic               done_d_reg;
  logic [6:0]         stb_prev_reg;
  logic               rqs_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;
  logic               op_start_reg;
  logic               rst_act_reg;
  logic               irq_reg;
  logic               wr_acc;
  logic               rd_acc;
  logic               cmd_wr;
  logic               cmd_ok;
  logic [3:0]         cmd_code;
  logic               pending;
  logic               done_pulse;
  logic               ovl_start;
  logic               rst_start;
  logic               cls_exec;
  logic               opc_set;
  logic               refused;
  logic               bad_cmd;
  logic               reply_push;
  logic [6:0]         stb_now;
  logic               srq_rise;

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `CS_OFF_CMD, `CS_OFF_ESR, `CS_OFF_ESE, `CS_OFF_SRE, `CS_OFF_STB,
      `CS_OFF_OUTQ, `CS_OFF_STAT, `CS_OFF_ISTAT, `CS_OFF_IMASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  assign wr_acc = psel && penable && pready_reg && pwrite && addr_ok(paddr);
  assign rd_acc = psel && penable && pready_reg && !pwrite && addr_ok(paddr);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !addr_ok(paddr);
      if (psel && penable && !pready_reg && !pwrite) begin
        case (paddr)
          `CS_OFF_ESR:   prdata_reg <= {24'h0, esr_reg};
          `CS_OFF_ESE:   prdata_reg <= {24'h0, ese_reg};
          `CS_OFF_SRE:   prdata_reg <= {24'h0, sre_reg};
          `CS_OFF_STB:   prdata_reg <= {25'h0, stb_now};
          `CS_OFF_OUTQ:  prdata_reg <= {24'h0, oq.empty ? 8'h00 : oq.rdata};
          `CS_OFF_STAT:  prdata_reg <= {16'h0, 4'(PEND_W'(pend_cnt_reg)), 1'b0,
                                         rst_act_reg, opc_pend_reg, state_reg == CS_IDLE,
                                         6'h0, state_reg};
          `CS_OFF_ISTAT: prdata_reg <= {24'h0, istat_reg};
          `CS_OFF_IMASK: prdata_reg <= {24'h0, imask_reg};
          default:       prdata_reg <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Completion input synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_d_reg  <= 1'b0;
    end else begin
      done_s1_reg <= i_op_done;
      done_s2_reg <= done_s1_reg;
      done_d_reg  <= done_s2_reg;
    end
  end
  assign done_pulse = done_s2_reg && !done_d_reg;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign cmd_wr     = wr_acc && (paddr == `CS_OFF_CMD);
  assign cmd_code   = pwdata[3:0];
  assign cmd_ok     = cmd_wr && (state_reg == CS_IDLE);
  assign refused    = cmd_wr && (state_reg != CS_IDLE);
  assign bad_cmd    = cmd_ok && !(cmd_code inside {`CS_CMD_OPC, `CS_CMD_OPCQ, `CS_CMD_WAI,
                                                   `CS_CMD_RST, `CS_CMD_CLS, `CS_CMD_OVL});
  assign ovl_start  = cmd_ok && (cmd_code == `CS_CMD_OVL);
  assign rst_start  = cmd_ok && (cmd_code == `CS_CMD_RST);
  assign cls_exec   = cmd_ok && (cmd_code == `CS_CMD_CLS);
  assign pending    = (pend_cnt_reg != '0) || rst_act_reg;
  assign reply_push = (state_reg == CS_OPCQ) && !pending && !oq.full;
  assign opc_set    = (cmd_ok && (cmd_code == `CS_CMD_OPC) && !pending)
                      || (opc_pend_reg && !pending && !cls_exec);

  assign oq.push  = reply_push;
  assign oq.wdata = `CS_REPLY_ONE;
  assign oq.pop   = rd_acc && (paddr == `CS_OFF_OUTQ);

  cmdsync_outq #(
    .DEPTH (OQ_DEPTH)
  ) u_outq (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .q       (oq)
  );

  // ----------------------------------------
  // Overlapped operation tracking
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_cnt_reg <= '0;
      op_start_reg <= 1'b0;
    end else begin
      op_start_reg <= ovl_start;
      if (ovl_start && !(done_pulse && pend_cnt_reg != '0) && pend_cnt_reg != '1) begin
        pend_cnt_reg <= pend_cnt_reg + 1'b1;
      end else if (!ovl_start && done_pulse && pend_cnt_reg != '0) begin
        pend_cnt_reg <= pend_cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_cnt_reg <= '0;
      rst_act_reg <= 1'b0;
    end else if (rst_start) begin
      rst_cnt_reg <= 32'(RST_CYCLES);
      rst_act_reg <= 1'b1;
    end else if (rst_cnt_reg != '0) begin
      rst_cnt_reg <= rst_cnt_reg - 1'b1;
      rst_act_reg <= (rst_cnt_reg != 32'd1);
    end
  end

  // ----------------------------------------
  // Sequencing state machine
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= CS_IDLE;
    end else begin
      case (state_reg)
        CS_IDLE: begin
          if (cmd_ok && cmd_code == `CS_CMD_WAI) state_reg <= CS_WAI;
          else if (cmd_ok && cmd_code == `CS_CMD_OPCQ) state_reg <= CS_OPCQ;
        end
        CS_WAI: begin
          if (!pending) state_reg <= CS_IDLE;
        end
        CS_OPCQ: begin
          if (reply_push) state_reg <= CS_IDLE;
        end
        default: state_reg <= CS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      opc_pend_reg <= 1'b0;
    end else if (cls_exec || opc_set) begin
      opc_pend_reg <= 1'b0;
    end else if (cmd_ok && cmd_code == `CS_CMD_OPC) begin
      opc_pend_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Event status, enables, status byte
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      esr_reg <= `CS_RST_8;
    end else begin
      if (cls_exec || (rd_acc && paddr == `CS_OFF_ESR)) esr_reg <= `CS_RST_8;
      if (opc_set) esr_reg[`CS_ESR_OPC] <= 1'b1;
      if (refused) esr_reg[`CS_ESR_REF] <= 1'b1;
      if (bad_cmd) esr_reg[`CS_ESR_CME] <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ese_reg   <= `CS_RST_8;
      sre_reg   <= `CS_RST_8;
      imask_reg <= `CS_RST_8;
    end else if (wr_acc) begin
      if (paddr == `CS_OFF_ESE) ese_reg <= pwdata[7:0];
      if (paddr == `CS_OFF_SRE) sre_reg <= pwdata[7:0];
      if (paddr == `CS_OFF_IMASK) imask_reg <= pwdata[7:0];
    end
  end

  always_comb begin
    stb_now = '0;
    stb_now[`CS_STB_MAV] = !oq.empty;
    stb_now[`CS_STB_ESB] = |(esr_reg & ese_reg);
    stb_now[`CS_STB_MSS] = |(stb_now[5:0] & sre_reg[5:0]);
  end
  assign srq_rise = |(stb_now[5:0] & ~stb_prev_reg[5:0] & sre_reg[5:0]);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stb_prev_reg <= '0;
      rqs_reg      <= 1'b0;
    end else begin
      stb_prev_reg <= stb_now;
      if (srq_rise) rqs_reg <= 1'b1;
      else if (cls_exec || (rd_acc && paddr == `CS_OFF_STB)) rqs_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Interrupt status and output
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      istat_reg <= `CS_RST_8;
      irq_reg   <= 1'b0;
    end else begin
      if (cls_exec || (rd_acc && paddr == `CS_OFF_ISTAT)) istat_reg <= `CS_RST_8;
      if (opc_set) istat_reg[`CS_INT_OPC] <= 1'b1;
      if (reply_push) istat_reg[`CS_INT_REPLY] <= 1'b1;
      if (refused) istat_reg[`CS_INT_REF] <= 1'b1;
      if (srq_rise) istat_reg[`CS_INT_SRQ] <= 1'b1;
      irq_reg <= |(istat_reg & imask_reg);
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign o_op_start   = op_start_reg;
  assign o_rst_active = rst_act_reg;
  assign o_srq        = rqs_reg;
  assign o_irq        = irq_reg;
  assign o_state      = state_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_opc_cmd;
    cmd_ok && cmd_code == `CS_CMD_OPC && !cls_exec;
  endsequence
  sequence s_idle_cmd;
    !pending;
  endsequence

  opc_no_early_a: assert property (opc_pend_reg && pending |=> !$rose(esr_reg[0]) || opc_pend_reg)
    else $error("OPC bit set while operations pending");
  opc_now_a: assert property (s_opc_cmd ##0 s_idle_cmd |=> esr_reg[0])
    else $error("OPC with nothing pending did not set bit");
  opcq_reply_a: assert property (state_reg == CS_OPCQ && !pending && !oq.full |=> state_reg == CS_IDLE ##1 !oq.empty)
    else $error("OPC query reply not queued");
  wai_hold_a: assert property (state_reg == CS_WAI && pending |=> state_reg == CS_WAI)
    else $error("WAI released while pending");
  esb_mask_a: assert property (esr_reg[0] && ese_reg[0] |-> stb_now[`CS_STB_ESB])
    else $error("ESB not set by enabled OPC");
  srq_raise_a: assert property (srq_rise |=> o_srq)
    else $error("Service request not raised");
  rst_len_a: assert property (rst_start |=> o_rst_active [*8])
    else $error("Reset activity ended too soon");
  cls_drop_a: assert property (cls_exec |=> !opc_pend_reg && esr_reg == 8'h00)
    else $error("CLS did not clear pending OPC or ESR");
  esr_clear_a: assert property (rd_acc && paddr == `CS_OFF_ESR && !opc_set && !refused |=> esr_reg == 8'h00)
    else $error("ESR read did not clear");
  poll_busy_a: assert property (psel && penable && !pready_reg |=> pready_reg)
    else $error("Status read stalled while busy");
  cmd_refuse_a: assert property (state_reg != CS_IDLE |-> !cmd_ok)
    else $error("Command executed while blocked");
endmodule

// ===== bench/cmdsync_engine_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Overlapped-operation engine model
// ----------------------------------------
module cmdsync_engine_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic [7:0] i_delay,
  output logic            o_done
);
  int unsigned open_cnt;
  int unsigned wait_cnt;

  // One start, one done rise; ops finish one at a time
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open_cnt <= 0;
      wait_cnt <= 0;
      o_done   <= 1'b0;
    end else begin
      if (i_start && !(open_cnt != 0 && wait_cnt == i_delay + 8)) begin
        open_cnt <= open_cnt + 1;
      end else if (!i_start && open_cnt != 0 && wait_cnt == i_delay + 8) begin
        open_cnt <= open_cnt - 1;
      end
      if (open_cnt == 0 || wait_cnt == i_delay + 8) begin
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
      // Level held 4 cycles so the two-flop sync sees each rise
      o_done <= (open_cnt != 0) && (wait_cnt >= i_delay) && (wait_cnt < i_delay + 4);
    end
  end
endmodule

// ===== bench/cmdsync_tb_top.sv
`timescale 1ns/1ps
`include "cmdsync_regs.svh"
module cmdsync_tb_top;
  import cmdsync_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        i_op_done;
  logic        o_op_start;
  logic        o_rst_active;
  logic        o_srq;
  logic        o_irq;
  cs_state_e   o_state;
  logic [7:0]  delay = 8'h28;
  logic [31:0] r;
  logic [31:0] v;
  logic        last_err;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;

  always #5 i_clk = ~i_clk;

  cmdsync #(.RST_CYCLES(30)) u_cmdsync (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_op_done(i_op_done), .o_op_start(o_op_start), .o_rst_active(o_rst_active),
    .o_srq(o_srq), .o_irq(o_irq), .o_state(o_state)
  );

  cmdsync_engine_model u_cmdsync_engine_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(o_op_start), .i_delay(delay), .o_done(i_op_done)
  );

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_srq();
    for (n = 0; n < 400 && o_srq !== 1'b1; n++) @(posedge i_clk);
    @(posedge i_clk);
  endtask

  function automatic logic [31:0] stb_exp(logic [7:0] esr, logic [7:0] ese, logic [7:0] sre, logic mav);
    logic [7:0] s;
    s = 8'h00;
    s[4] = mav;
    s[5] = |(esr & ese);
    s[6] = |(s[5:0] & sre[5:0]);
    return {24'h0, s};
  endfunction

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(13906));
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    apb(0, `CS_OFF_ESR, 0);  chk("esr_rst", r, 32'h0);
    chk("map_ok", {31'h0, last_err}, 32'h0);
    apb(0, 8'h24, 0);        chk("unmapped", {31'h0, last_err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      pwdata <= 32'h0;
      v = $urandom();
      apb(1, `CS_OFF_ESE, v);
      apb(0, `CS_OFF_ESE, 0);
      chk("ese_rw", r, {24'h0, v[7:0]});
      chk("ese_hi", r & 32'hffffff00, 32'h0);
    end
    apb(1, `CS_OFF_CMD, `CS_CMD_OPC);
    apb(0, `CS_OFF_ESR, 0);  chk("opc_idle", r, 32'h1);
    apb(0, `CS_OFF_ESR, 0);  chk("esr_clr", r, 32'h0);
    // OPC through ESB service request
    apb(1, `CS_OFF_ESE, 32'h1);
    apb(1, `CS_OFF_SRE, 32'h20);
    apb(1, `CS_OFF_IMASK, 32'h1);
    apb(1, `CS_OFF_CMD, `CS_CMD_OVL);
    apb(1, `CS_OFF_CMD, `CS_CMD_OPC);
    apb(0, `CS_OFF_ESR, 0);  chk("opc_early", r, 32'h0);
    chk("srq_early", {31'h0, o_srq}, 32'h0);
    wait_srq();
    chk("srq_esb", {31'h0, o_srq}, 32'h1);
    chk("irq_set", {31'h0, o_irq}, 32'h1);
    apb(0, `CS_OFF_STB, 0);  chk("stb_esb", r, stb_exp(8'h01, 8'h01, 8'h20, 1'b0));
    apb(0, `CS_OFF_ISTAT, 0); chk("istat", r, 32'h9);
    apb(0, `CS_OFF_ESR, 0);  chk("opc_done", r & 32'h1, 32'h1);
    chk("irq_clr", {31'h0, o_irq}, 32'h0);
    chk("srq_clr", {31'h0, o_srq}, 32'h0);
    // OPC? with message-available request, command refused while blocked
    delay <= 8'(20 + ($urandom() % 60));
    apb(1, `CS_OFF_ESE, 32'h0);
    apb(1, `CS_OFF_SRE, 32'h10);
    apb(1, `CS_OFF_IMASK, 32'h0);
    apb(1, `CS_OFF_CMD, `CS_CMD_OVL);
    apb(1, `CS_OFF_CMD, `CS_CMD_OPCQ);
    @(posedge i_clk);
    chk("state_opcq", {30'h0, o_state}, {30'h0, CS_OPCQ});
    apb(0, `CS_OFF_STAT, 0); chk("stat_busy", r & 32'h3, {30'h0, CS_OPCQ});
    apb(1, `CS_OFF_CMD, `CS_CMD_OPC);
    apb(0, `CS_OFF_OUTQ, 0); chk("outq_early", r, 32'h0);
    wait_srq();
    chk("srq_mav", {31'h0, o_srq}, 32'h1);
    chk("irq_mask", {31'h0, o_irq}, 32'h0);
    apb(0, `CS_OFF_OUTQ, 0); chk("outq_one", r, {24'h0, `CS_REPLY_ONE});
    apb(0, `CS_OFF_ESR, 0);  chk("esr_ref", r, 32'h4);
    apb(0, `CS_OFF_ISTAT, 0); chk("istat_q", r, 32'he);
    chk("state_back", {30'h0, o_state}, {30'h0, CS_IDLE});
    // Wait-to-continue
    apb(1, `CS_OFF_CMD, `CS_CMD_OVL);
    @(posedge i_clk);
    chk("op_start", {31'h0, o_op_start}, 32'h1);
    apb(1, `CS_OFF_CMD, `CS_CMD_WAI);
    @(posedge i_clk);
    chk("state_wai", {30'h0, o_state}, {30'h0, CS_WAI});
    for (n = 0; n < 400 && o_state !== CS_IDLE; n++) @(posedge i_clk);
    chk("wai_end", {30'h0, o_state}, {30'h0, CS_IDLE});
    // Reset is overlapped
    apb(1, `CS_OFF_CMD, `CS_CMD_RST);
    apb(1, `CS_OFF_CMD, `CS_CMD_OPC);
    chk("rst_act", {31'h0, o_rst_active}, 32'h1);
    apb(0, `CS_OFF_ESR, 0);  chk("rst_early", r, 32'h0);
    for (n = 0; n < 100 && o_rst_active !== 1'b0; n++) @(posedge i_clk);
    apb(0, `CS_OFF_ESR, 0);  chk("rst_opc", r, 32'h1);
    // Clear status drops a pending OPC
    apb(1, `CS_OFF_CMD, `CS_CMD_OVL);
    apb(1, `CS_OFF_CMD, `CS_CMD_OPC);
    apb(1, `CS_OFF_CMD, `CS_CMD_CLS);
    r = 32'hffff;
    for (n = 0; n < 60 && r[15:12] != 4'h0; n++) apb(0, `CS_OFF_STAT, 0);
    apb(0, `CS_OFF_ESR, 0);  chk("cls_skip", r, 32'h0);
    apb(0, `CS_OFF_ISTAT, 0); chk("cls_istat", r, 32'h0);
    apb(1, `CS_OFF_CMD, `CS_CMD_OPC);
    apb(0, `CS_OFF_ESR, 0);  chk("opc_again", r, 32'h1);
    apb(1, `CS_OFF_CMD, 32'hf);
    apb(0, `CS_OFF_ESR, 0);  chk("bad_cmd", r, 32'h20);
    wrap_up();
  end
endmodule
